// file: bench/skp_check_tb.sv
`timescale 1ns/1ps
`include "skp_regs.svh"

module skp_check_tb;
	import skp_pkg::*;

	`define TB_CHK(what, exp, got) begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_sys_i, rst_n_i, supervisor_i, key_op_valid_i, key_op_write_i, mem_rvalid_i;
	logic key_op_done_o, key_op_reject_o, req_ready_o, rdata_valid_o, rdata_blocked_o;
	logic prot_exc_o, prot_exc_io_o, prog_exc_irq_o, mem_req_o, mem_abort_o;
	logic [`SKP_PSW_W-1:0] program_status_word_i;
	logic [`SKP_ADDR_W-1:0] key_op_addr_i;
	logic [`SKP_OWNER_W-1:0] reloc_key_o;
	logic [`SKP_DATA_W-1:0] rdata_o, mem_wdata_o, mem_rdata_i;
	logic [`SKP_WORD_W-1:0] mem_addr_o;
	logic [`SKP_BYTE_LANES-1:0] mem_byte_wr_o;
	logic [3:0] lat;
	skp_mode_s mode_i;
	skp_key_s key_op_wkey_i, key_op_rkey_o;
	skp_req_s req_i;
	skp_key_s shadow [int];
	int n_mismatch, samples_checked, cyc;
	localparam logic [31:0] wdat = 32'h4c3b_2a19;
	localparam skp_mode_s m_none = 3'h0;
	localparam skp_mode_s m_esc = 3'h4;
	localparam skp_mode_s m_trc = 3'h2;
	localparam skp_mode_s m_sim = 3'h1;
	localparam skp_mode_s m_ts = 3'h3;

	skp_check #(.KEY_DEPTH(512)) skp_check_inst (
		.clk_sys_i, .rst_n_i, .program_status_word_i, .mode_i, .supervisor_i,
		.key_op_valid_i, .key_op_write_i, .key_op_addr_i, .key_op_wkey_i, .key_op_done_o,
		.key_op_reject_o, .key_op_rkey_o, .req_i, .req_ready_o, .reloc_key_o, .rdata_valid_o,
		.rdata_o, .rdata_blocked_o, .prot_exc_o, .prot_exc_io_o, .prog_exc_irq_o, .mem_req_o,
		.mem_addr_o, .mem_byte_wr_o, .mem_wdata_o, .mem_abort_o, .mem_rvalid_i, .mem_rdata_i
	);

	skp_mem_model skp_mem_model_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req_o),
		.mem_addr_i(mem_addr_o), .mem_byte_wr_i(mem_byte_wr_o), .mem_wdata_i(mem_wdata_o),
		.mem_abort_i(mem_abort_o), .lat_i(lat), .mem_rvalid_o(mem_rvalid_i),
		.mem_rdata_o(mem_rdata_i)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One key instruction; k is the key to set or the key expected back
	task automatic key_op(input logic w, input logic s, input logic [23:0] a, input skp_key_s k);
		@(posedge clk_sys_i);
		supervisor_i <= s;
		key_op_valid_i <= 1'b1;
		key_op_write_i <= w;
		key_op_addr_i <= a;
		key_op_wkey_i <= k;
		@(posedge clk_sys_i);
		key_op_valid_i <= 1'b0;
		#1;
		`TB_CHK("key op done", s, key_op_done_o);
		`TB_CHK("key op refused", !s, key_op_reject_o);
		if (s && w) shadow[int'(a[23:11])] = k;
		if (s && !w) `TB_CHK("inserted key", k, key_op_rkey_o);
	endtask

	// One storage reference, judged against a grant worked out here
	task automatic acc(input logic io, input logic [3:0] k, input logic [23:0] a,
		input logic [3:0] bw, input logic ia, input logic tt, input skp_mode_s m,
		input logic pr, input logic [3:0] dly);
		skp_key_s b;
		logic wr, g;
		logic [31:0] old, expd;
		int n;
		b = shadow.exists(int'(a[23:11])) ? shadow[int'(a[23:11])] : `SKP_KEY_RST;
		wr = (bw != `SKP_NO_BYTES);
		g = (b.owner == k) || (k == 4'h0) || (!io && m.escape) || (!wr && !b.read_protect_flag)
			|| (!io && ia && b.owner == 4'hf) || (!io && wr && tt && m.trace && m.simulation_state_mode);
		old = skp_mem_model_inst.store_q[a[9:2]];
		for (int i = 0; i < 4; i++) expd[8*i+:8] = (g && bw[i]) ? wdat[8*i+:8] : old[8*i+:8];
		@(posedge clk_sys_i);
		mode_i <= m;
		lat <= dly;
		// Wrong key on the unused source catches a mixed-up key selection
		program_status_word_i <= {20'h5a5a5, io ? ~k : k, 8'ha5};
		req_i <= '{1'b1, io, io ? k : ~k, a, bw, wdat, ia, tt, pr};
		@(posedge clk_sys_i);
		req_i.valid <= 1'b0;
		#1;
		`TB_CHK("storage cycle", 1'b1, mem_req_o);
		`TB_CHK("exception", !g, prot_exc_o);
		`TB_CHK("abort", wr && !g, mem_abort_o);
		`TB_CHK("io exception", io && !g, prot_exc_io_o);
		`TB_CHK("interrupt", pr && !io && !g, prog_exc_irq_o);
		`TB_CHK("reloc key", k, reloc_key_o);
		`TB_CHK("word addr", a[23:2], mem_addr_o);
		`TB_CHK("byte lines", bw, mem_byte_wr_o);
		`TB_CHK("ready", wr, req_ready_o);
		if (wr) begin
			@(posedge clk_sys_i);
			#1;
			`TB_CHK("stored word", expd, skp_mem_model_inst.store_q[a[9:2]]);
		end else begin
			n = 0;
			while (rdata_valid_o !== 1'b1 && rdata_blocked_o !== 1'b1 && n < 40) begin
				@(posedge clk_sys_i);
				#1;
				n++;
			end
			`TB_CHK("read valid", g, rdata_valid_o);
			`TB_CHK("read blocked", !g, rdata_blocked_o);
			if (g) `TB_CHK("read data", old, rdata_o);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic scen_keys;
		#1;
		`TB_CHK("ready after reset", 1'b1, req_ready_o);
		key_op('0, '1, 24'h000000, 5'h00);
		key_op('1, '0, 24'h000800, 5'h0b);
		key_op('0, '0, 24'h000800, 5'h00);
		key_op('0, '1, 24'h000800, 5'h00);
		// Owner code sits in the high four key bits, flag in the low bit
		key_op('1, '1, 24'h000800, 5'h0b);
		key_op('1, '1, 24'h001000, 5'h0a);
		key_op('1, '1, 24'h001800, 5'h1f);
		key_op('1, '1, 24'h0ff800, 5'h0f);
		key_op('0, '1, 24'h000fff, 5'h0b);
		key_op('0, '1, 24'h001000, 5'h0a);
		key_op('0, '1, 24'h0ff800, 5'h0f);
	endtask

	// Owner match, zero key, read-protect flag, block edges
	task automatic scen_match;
		acc('0, 4'h5, 24'h000800, 4'hf, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h3, 24'h000804, 4'hf, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h3, 24'h000804, 4'hf, '0, '0, m_none, '0, 4'h0);
		acc('0, 4'h3, 24'h000808, 4'h0, '0, '0, m_none, '1, 4'h5);
		acc('0, 4'h3, 24'h001000, 4'h0, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h3, 24'h001004, 4'h5, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h0, 24'h000800, 4'h2, '0, '0, m_none, '1, 4'h0);
		acc('1, 4'h5, 24'h000808, 4'h0, '0, '0, m_none, '0, 4'h3);
		acc('1, 4'h3, 24'h000808, 4'h0, '0, '0, m_none, '0, 4'h1);
		acc('0, 4'h5, 24'h0017fc, 4'hf, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h5, 24'h001800, 4'hf, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h7, 24'h0ff800, 4'h0, '0, '0, m_none, '1, 4'h2);
		acc('0, 4'h3, 24'h0ff800, 4'h0, '0, '0, m_none, '1, 4'h0);
	endtask

	// Escape, indirect word and trace-table grants
	task automatic scen_special;
		acc('0, 4'h3, 24'h000800, 4'hf, '0, '0, m_esc, '1, 4'h0);
		acc('1, 4'h3, 24'h000800, 4'hf, '0, '0, m_esc, '0, 4'h0);
		acc('1, 4'h3, 24'h000808, 4'h0, '0, '0, m_esc, '0, 4'h0);
		acc('0, 4'h3, 24'h001800, 4'hc, '1, '0, m_none, '1, 4'h0);
		acc('0, 4'h3, 24'h001800, 4'h0, '1, '0, m_none, '1, 4'h4);
		acc('0, 4'h3, 24'h001800, 4'hf, '0, '0, m_none, '1, 4'h0);
		acc('0, 4'h3, 24'h000800, 4'hf, '1, '0, m_none, '1, 4'h0);
		acc('0, 4'h3, 24'h000800, 4'hf, '0, '1, m_ts, '1, 4'h0);
		acc('0, 4'h3, 24'h000800, 4'hf, '0, '1, m_trc, '1, 4'h0);
		acc('0, 4'h3, 24'h000800, 4'hf, '0, '1, m_sim, '1, 4'h0);
		acc('0, 4'h3, 24'h000808, 4'h0, '0, '1, m_ts, '1, 4'h0);
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// Under two hundred cycles are needed; the ceiling leaves wide margin
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		rst_n_i = 1'b0;
		supervisor_i = 1'b0;
		key_op_valid_i = 1'b0;
		key_op_write_i = 1'b0;
		key_op_addr_i = '0;
		key_op_wkey_i = '0;
		program_status_word_i = '0;
		mode_i = m_none;
		req_i = '0;
		lat = 4'h0;
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		scen_keys();
		scen_match();
		scen_special();
		tally_and_finish();
	end
endmodule

// file: bench/skp_mem_model.sv
`timescale 1ns/1ps
`include "skp_regs.svh"

module skp_mem_model (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Storage cycle from the checker
	input wire logic mem_req_i,
	input wire logic [`SKP_WORD_W-1:0] mem_addr_i,
	input wire logic [`SKP_BYTE_LANES-1:0] mem_byte_wr_i,
	input wire logic [`SKP_DATA_W-1:0] mem_wdata_i,
	input wire logic mem_abort_i,
	// Read answer delay in cycles
	input wire logic [3:0] lat_i,
	// Read answer
	output logic mem_rvalid_o,
	output logic [`SKP_DATA_W-1:0] mem_rdata_o
);
	logic [`SKP_DATA_W-1:0] store_q [256];
	logic [`SKP_DATA_W-1:0] hold_q;
	logic busy_q;
	logic [3:0] cnt_q;

	// Small window of storage, aliased on the low word bits
	initial begin
		for (int i = 0; i < 256; i++) begin
			store_q[i] = 32'h9e37_79b9 * (i + 1);
		end
		busy_q = 1'b0;
		mem_rvalid_o = 1'b0;
		mem_rdata_o = 32'h0000_0000;
	end

	// Read data bus toggles when idle, so a stale sample never looks valid
	always @(posedge clk_sys_i) begin
		mem_rvalid_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (!rst_n_i) begin
			busy_q <= 1'b0;
		end else if (busy_q && cnt_q == 4'h0) begin
			mem_rvalid_o <= 1'b1;
			mem_rdata_o <= hold_q;
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
		if (rst_n_i && mem_req_i && mem_byte_wr_i == `SKP_NO_BYTES) begin
			busy_q <= 1'b1;
			cnt_q <= lat_i;
			hold_q <= store_q[mem_addr_i[7:0]];
		end else if (rst_n_i && mem_req_i && !mem_abort_i) begin
			for (int b = 0; b < 4; b++) begin
				if (mem_byte_wr_i[b]) begin
					store_q[mem_addr_i[7:0]][8*b+:8] <= mem_wdata_i[8*b+:8];
				end
			end
		end
		// An aborted write leaves the word untouched
	end
endmodule

// file: logic/skp_check.sv
`timescale 1ns/1ps
`include "skp_regs.svh"

module skp_check #(
	parameter int KEY_DEPTH = `SKP_MAX_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Processor state
	input wire logic [`SKP_PSW_W-1:0] program_status_word_i,
	input wire skp_pkg::skp_mode_s mode_i,
	input wire logic supervisor_i,
	// Key instructions
	input wire logic key_op_valid_i,
	input wire logic key_op_write_i,
	input wire logic [`SKP_ADDR_W-1:0] key_op_addr_i,
	input wire skp_pkg::skp_key_s key_op_wkey_i,
	output logic key_op_done_o,
	output logic key_op_reject_o,
	output skp_pkg::skp_key_s key_op_rkey_o,
	// Storage references
	input wire skp_pkg::skp_req_s req_i,
	output logic req_ready_o,
	output logic [`SKP_OWNER_W-1:0] reloc_key_o,
	output logic rdata_valid_o,
	output logic [`SKP_DATA_W-1:0] rdata_o,
	output logic rdata_blocked_o,
	output logic prot_exc_o,
	output logic prot_exc_io_o,
	output logic prog_exc_irq_o,
	// Main storage
	output logic mem_req_o,
	output logic [`SKP_WORD_W-1:0] mem_addr_o,
	output logic [`SKP_BYTE_LANES-1:0] mem_byte_wr_o,
	output logic [`SKP_DATA_W-1:0] mem_wdata_o,
	output logic mem_abort_o,
	input wire logic mem_rvalid_i,
	input wire logic [`SKP_DATA_W-1:0] mem_rdata_i
);
	import skp_pkg::*;

	localparam int IDX_W = $clog2(KEY_DEPTH);

	// ----------------------------------------------------------------
	// Elaboration check on the key memory size
	// ----------------------------------------------------------------
	// Depth must be a power of two in the supported range
	if (KEY_DEPTH < `SKP_MIN_DEPTH || KEY_DEPTH > `SKP_MAX_DEPTH
		|| (1 << IDX_W) != KEY_DEPTH) begin : g_bad_depth
		$error("skp_check: KEY_DEPTH must be a power of two from 64 to 512");
	end

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	skp_state_e state_q;
	skp_state_e state_d;
	logic taken;
	logic is_write;
	logic [`SKP_OWNER_W-1:0] req_key;
	logic [`SKP_IDX_W-1:0] blk_idx;
	logic [IDX_W-1:0] chk_idx;
	logic [IDX_W-1:0] op_idx;
	skp_key_s chk_key;
	skp_key_s op_key;
	logic grant;
	logic key_op_ok;

	// One read outstanding at a time; writes also wait while it is outstanding
	assign req_ready_o = state_q == SKP_IDLE;
	assign taken = req_i.valid && req_ready_o;
	assign is_write = req_i.byte_wr != `SKP_NO_BYTES;
	// Processor key from the status word, channels supply theirs
	assign req_key = req_i.is_io ? req_i.io_key
		: program_status_word_i[`SKP_PSW_KEY_MSB:`SKP_PSW_KEY_LSB];
	// Top 13 address bits pick the block key
	assign blk_idx = req_i.addr[`SKP_ADDR_W-1:`SKP_BLOCK_LSB];
	// Smaller storage uses only the low index bits; high ones are the
	// storage's addressing exception, not ours
	assign chk_idx = blk_idx[IDX_W-1:0];
	assign op_idx = key_op_addr_i[`SKP_BLOCK_LSB+IDX_W-1:`SKP_BLOCK_LSB];
	assign key_op_ok = key_op_valid_i && supervisor_i;

	// ----------------------------------------------------------------
	// Key memory and grant logic
	// ----------------------------------------------------------------
	skp_key_mem #(
		.DEPTH(KEY_DEPTH),
		.IDX_W(IDX_W)
	) u_key_mem (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(key_op_ok && key_op_write_i),
		.wr_idx_i(op_idx),
		.wr_key_i(key_op_wkey_i),
		.chk_idx_i(chk_idx),
		.chk_key_o(chk_key),
		.rd_idx_i(op_idx),
		.rd_key_o(op_key)
	);

	// Decided combinationally so a refused write reaches storage already marked for abort
	skp_grant u_grant (
		.blk_key_i(chk_key),
		.req_key_i(req_key),
		.is_io_i(req_i.is_io),
		.is_write_i(is_write),
		.indirect_address_control_word_i(req_i.indirect_address_control_word),
		.trace_table_i(req_i.trace_table),
		.mode_i(mode_i),
		.grant_o(grant)
	);

	// ----------------------------------------------------------------
	// Key instruction results
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			key_op_done_o <= 1'b0;
			key_op_reject_o <= 1'b0;
			key_op_rkey_o <= `SKP_KEY_RST;
		end else begin
			key_op_done_o <= key_op_ok;
			key_op_reject_o <= key_op_valid_i && !supervisor_i;
			if (key_op_ok && !key_op_write_i) begin
				key_op_rkey_o <= op_key;
			end
		end
	end

	// ----------------------------------------------------------------
	// Storage cycle issue
	// ----------------------------------------------------------------
	// Denied writes still start a cycle, marked for abort, so storage
	// timing stays the same whatever the outcome
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mem_req_o <= 1'b0;
			mem_addr_o <= '0;
			mem_byte_wr_o <= `SKP_NO_BYTES;
			mem_wdata_o <= '0;
			mem_abort_o <= 1'b0;
			reloc_key_o <= `SKP_OWNER_ZERO;
		end else begin
			mem_req_o <= taken;
			mem_abort_o <= taken && is_write && !grant;
			if (taken) begin
				mem_addr_o <= req_i.addr[`SKP_ADDR_W-1:`SKP_WORD_LSB];
				mem_byte_wr_o <= req_i.byte_wr;
				mem_wdata_o <= req_i.wdata;
				reloc_key_o <= req_key;
			end
		end
	end

	// ----------------------------------------------------------------
	// Exceptions
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			prot_exc_o <= 1'b0;
			prot_exc_io_o <= 1'b0;
			prog_exc_irq_o <= 1'b0;
		end else begin
			prot_exc_o <= taken && !grant;
			prot_exc_io_o <= taken && !grant && req_i.is_io;
			// Channel exceptions are the channel's to handle
			prog_exc_irq_o <= taken && !grant && req_i.prog_ref && !req_i.is_io;
		end
	end

	// ----------------------------------------------------------------
	// Read tracking and data suppression
	// ----------------------------------------------------------------
	logic blocked_q;
	logic blocked_d;

	always_comb begin
		state_d = state_q;
		blocked_d = blocked_q;
		case (state_q)
			SKP_IDLE: begin
				if (taken && !is_write) begin
					state_d = SKP_RD_WAIT;
					blocked_d = !grant;
				end
			end
			SKP_RD_WAIT: begin
				if (mem_rvalid_i) begin
					state_d = SKP_IDLE;
					blocked_d = 1'b0;
				end
			end
			default: begin
				state_d = SKP_IDLE;
				blocked_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q <= SKP_IDLE;
			blocked_q <= 1'b0;
		end else begin
			state_q <= state_d;
			blocked_q <= blocked_d;
		end
	end

	// Refused data never leaves the block, not even on the data lines
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_valid_o <= 1'b0;
			rdata_blocked_o <= 1'b0;
			rdata_o <= '0;
		end else begin
			rdata_valid_o <= state_q == SKP_RD_WAIT && mem_rvalid_i && !blocked_q;
			rdata_blocked_o <= state_q == SKP_RD_WAIT && mem_rvalid_i && blocked_q;
			if (state_q == SKP_RD_WAIT && mem_rvalid_i && !blocked_q) begin
				rdata_o <= mem_rdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_write_abort_deny: assert property (
		taken && is_write && !grant |=> mem_req_o && mem_abort_o && prot_exc_o)
		else $error("denied write was not aborted");

	a_write_commit_bytes: assert property (
		taken && is_write && grant |=> !mem_abort_o
			&& mem_byte_wr_o == $past(req_i.byte_wr))
		else $error("granted write lost its byte lanes");

	a_read_still_runs: assert property (
		taken && !is_write && !grant |=> mem_req_o && !mem_abort_o
			&& mem_byte_wr_o == `SKP_NO_BYTES)
		else $error("denied read did not start a storage cycle");

	a_read_data_blocked: assert property (
		state_q == SKP_RD_WAIT && blocked_q && mem_rvalid_i
			|=> !rdata_valid_o && rdata_blocked_o && $stable(rdata_o))
		else $error("blocked read data was passed on");

	a_zero_key_grant: assert property (
		taken && req_key == `SKP_OWNER_ZERO |=> !prot_exc_o)
		else $error("zero requester key was refused");

	a_escape_cpu_grant: assert property (
		taken && !req_i.is_io && mode_i.escape |=> !prot_exc_o && !mem_abort_o && !prog_exc_irq_o)
		else $error("escape mode reference was refused");

	a_open_read_grant: assert property (
		taken && !is_write && !chk_key.read_protect_flag |=> !prot_exc_o)
		else $error("read of write-only protected block was refused");

	a_indirect_address_control_word_all_ones: assert property (
		taken && !req_i.is_io && req_i.indirect_address_control_word
			&& chk_key.owner == `SKP_OWNER_ALL |=> !prot_exc_o)
		else $error("indirect word access to all-ones block was refused");

	a_irq_from_exc: assert property (
		taken && !grant && req_i.prog_ref && !req_i.is_io |=> prot_exc_o && prog_exc_irq_o)
		else $error("program reference exception raised no interrupt");

	a_key_op_refused: assert property (
		key_op_valid_i && !supervisor_i |=> key_op_reject_o && !key_op_done_o)
		else $error("key instruction outside supervisor mode not refused");

	a_reloc_key_source: assert property (
		taken && !req_i.is_io |=> reloc_key_o
			== $past(program_status_word_i[`SKP_PSW_KEY_MSB:`SKP_PSW_KEY_LSB]))
		else $error("relocation key not taken from status word");

	c_denied_write: cover property (taken && is_write && !grant ##1 mem_abort_o);
	c_blocked_read: cover property (rdata_blocked_o);
	c_indirect_address_control_word_grant: cover property (taken && req_i.indirect_address_control_word
		&& chk_key.owner == `SKP_OWNER_ALL && grant);
	c_key_refused: cover property (key_op_reject_o);

endmodule

// file: logic/skp_grant.sv
`timescale 1ns/1ps
`include "skp_regs.svh"

module skp_grant (
	// Looked-up block key and requester key
	input wire skp_pkg::skp_key_s blk_key_i,
	input wire logic [`SKP_OWNER_W-1:0] req_key_i,
	// Reference kind
	input wire logic is_io_i,
	input wire logic is_write_i,
	input wire logic indirect_address_control_word_i,
	input wire logic trace_table_i,
	// Processor mode
	input wire skp_pkg::skp_mode_s mode_i,
	// Decision
	output logic grant_o
);
	import skp_pkg::*;

	// ----------------------------------------------------------------
	// Grant terms
	// ----------------------------------------------------------------
	logic key_equal;
	logic key_master;
	logic escape_hit;
	logic match;
	logic indirect_address_control_word_hit;
	logic trace_hit;
	logic open_read;

	assign key_equal = blk_key_i.owner == req_key_i;
	assign key_master = req_key_i == `SKP_OWNER_ZERO;
	assign escape_hit = !is_io_i && mode_i.escape;
	assign match = key_equal || key_master || escape_hit;
	// Indirect word in an all-ones block ignores flag and key
	assign indirect_address_control_word_hit = !is_io_i && indirect_address_control_word_i && blk_key_i.owner == `SKP_OWNER_ALL;
	// Trace table writes in trace mode during simulation state
	assign trace_hit = !is_io_i && is_write_i && trace_table_i && mode_i.trace
		&& mode_i.simulation_state_mode;
	// Write-only protection still lets reads through
	assign open_read = !is_write_i && !blk_key_i.read_protect_flag;
	assign grant_o = match || indirect_address_control_word_hit || trace_hit || open_read;

endmodule

// file: logic/skp_key_mem.sv
`timescale 1ns/1ps
`include "skp_regs.svh"

module skp_key_mem #(
	parameter int DEPTH = `SKP_MAX_DEPTH,
	parameter int IDX_W = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Set-key write port
	input wire logic wr_en_i,
	input wire logic [IDX_W-1:0] wr_idx_i,
	input wire skp_pkg::skp_key_s wr_key_i,
	// Protection check read port
	input wire logic [IDX_W-1:0] chk_idx_i,
	output skp_pkg::skp_key_s chk_key_o,
	// Insert-key read port
	input wire logic [IDX_W-1:0] rd_idx_i,
	output skp_pkg::skp_key_s rd_key_o
);
	import skp_pkg::*;

	// ----------------------------------------------------------------
	// One key register per block, cleared at reset
	// ----------------------------------------------------------------
	skp_key_s key_q [DEPTH];

	// Entries are independent, so one owner may appear in many
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_sys_i) begin
			if (!rst_n_i) begin
				key_q[i] <= `SKP_KEY_RST;
			end else if (wr_en_i && wr_idx_i == IDX_W'(i)) begin
				key_q[i] <= wr_key_i;
			end
		end
	end

	// Reads are combinational so the check resolves in the request cycle
	assign chk_key_o = key_q[chk_idx_i];
	assign rd_key_o = key_q[rd_idx_i];

endmodule

// file: logic/skp_pkg.sv
`include "skp_regs.svh"

package skp_pkg;

	// ----------------------------------------------------------------
	// Block protection key: owner code in the high four bits, the
	// read-protect flag in the low bit (key bit 0 is the leftmost)
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`SKP_OWNER_W-1:0] owner;
		logic read_protect_flag;
	} skp_key_s;

	// ----------------------------------------------------------------
	// One storage reference from the processor or a channel
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic is_io;
		logic [`SKP_OWNER_W-1:0] io_key;
		logic [`SKP_ADDR_W-1:0] addr;
		logic [`SKP_BYTE_LANES-1:0] byte_wr;
		logic [`SKP_DATA_W-1:0] wdata;
		logic indirect_address_control_word;
		logic trace_table;
		logic prog_ref;
	} skp_req_s;

	// ----------------------------------------------------------------
	// Processor mode bits that widen the grant
	// ----------------------------------------------------------------
	typedef struct packed {
		logic escape;
		logic trace;
		logic simulation_state_mode;
	} skp_mode_s;

	// Read tracking states
	typedef enum logic [1:0] {
		SKP_IDLE = 2'b01,
		SKP_RD_WAIT = 2'b10
	} skp_state_e;

endpackage

// file: logic/skp_regs.svh
`ifndef SKP_CHECK_REGS_SVH
`define SKP_CHECK_REGS_SVH

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define SKP_ADDR_W 24
`define SKP_WORD_LSB 2
`define SKP_WORD_W 22
`define SKP_BLOCK_LSB 11
`define SKP_IDX_W 13
`define SKP_BYTE_LANES 4
`define SKP_DATA_W 32

// ----------------------------------------------------------------
// Block protection key layout
// ----------------------------------------------------------------
`define SKP_KEY_W 5
`define SKP_OWNER_W 4
`define SKP_RP_BIT 4
`define SKP_KEY_RST 5'h00
`define SKP_OWNER_ALL 4'hf
`define SKP_OWNER_ZERO 4'h0
`define SKP_NO_BYTES 4'h0

// ----------------------------------------------------------------
// Program status word key field (bits 20-23, bit 0 leftmost)
// ----------------------------------------------------------------
`define SKP_PSW_W 32
`define SKP_PSW_KEY_MSB 11
`define SKP_PSW_KEY_LSB 8

// ----------------------------------------------------------------
// Key memory depth limits
// ----------------------------------------------------------------
`define SKP_MIN_DEPTH 64
`define SKP_MAX_DEPTH 512

`endif
